// ==== design/dssq_host_seq.sv ====
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - hold device reset low at least 25 ns before any serial programming.
// - program serial registers after reset, before sync source setup.
// - set fuse sleep bit 11 of fuse control register during start-up.
// - set main control bit 2 to enable clock divider sync.
// - in PLL mode set PLL control bit 11 for divider sync.
// - present all LVDS inputs together, then issue the sync pulse.
// - single-source mode uses one rising edge, never periodic sync.
// - dual-source mode may use one pulse or repeating sync.
// - single-source mode clears main control bit 2 before transmission.
// - dual-source mode may leave divider sync enabled.
// - writing 0000 to both pointer source fields stops FIFO resync.
// - clear PLL control bit 11 after the initial sync pulses.
// - transmission starts only when transmit enable is raised, last step.
// - clock loss or collision drops transmit enable and repeats sync steps.
// - converter clock may come before or after serial programming.
module dssq_host_seq (
  input  wire logic                                ref_clk,
  input  wire logic                                sys_rst,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [31:0]                         reg_wdata,
  input  wire logic                                reg_we,
  input  wire logic                                reg_re,
  output logic      [31:0]                         reg_rdata,
  input  wire logic [dssq_pkg::ALARM_W-1:0]        alarm_pins,
  output logic                                     active_low_device_reset,
  output logic                                     transmit_enable_pin,
  output logic                                     lvds_enable,
  output logic                                     lvds_sync_input,
  output logic                                     input_strobe,
  output logic                                     sif_clk,
  output logic                                     sif_enable_n,
  output logic                                     sif_data
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_RST, ST_RECOVER, ST_W_FUSE, ST_W_SRC, ST_W_AUX, ST_W_MAIN,
    ST_W_PLL, ST_SYNC, ST_DIS_CLK, ST_DIS_FIFO, ST_DIS_PLL, ST_TX, ST_RUN
  } dssq_state_t;

  dssq_state_t               state_q;
  dssq_state_t               state_d;
  dssq_pkg::dssq_cfg_t       cfg_q;
  dssq_pkg::dssq_sif_req_t   req;
  logic                      is_write_st;
  logic                      skip_st;
  logic                      sent_q;
  logic                      req_valid;
  logic                      sif_busy;
  logic                      sif_done;
  logic [15:0]               main_base_q;
  logic [15:0]               fuse_base_q;
  logic [15:0]               src_base_q;
  logic [15:0]               aux_base_q;
  logic [15:0]               pll_base_q;
  logic [7:0]                wait_q;
  logic [3:0]                pulses_q;
  logic [7:0]                resync_cnt_q;
  logic [dssq_pkg::ALARM_W-1:0] alarm_s;
  logic [dssq_pkg::ALARM_W-1:0] alarm_flag_q;
  logic                      start_w;
  logic                      stop_w;
  logic                      resync_w;
  logic                      alarm_hit;
  logic                      sync_done;

  assign start_w  = reg_we && (reg_addr == dssq_pkg::OFS_CTRL)
                    && reg_wdata[dssq_pkg::CTRL_START_BIT];
  assign stop_w   = reg_we && (reg_addr == dssq_pkg::OFS_CTRL)
                    && reg_wdata[dssq_pkg::CTRL_STOP_BIT];
  assign resync_w = reg_we && (reg_addr == dssq_pkg::OFS_CTRL)
                    && reg_wdata[dssq_pkg::CTRL_RESYNC_BIT];
  assign alarm_hit = (alarm_s != '0);

  dssq_pin_sync #(
    .W (dssq_pkg::ALARM_W)
  ) u_alarm_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .pin_in   (alarm_pins),
    .pin_sync (alarm_s)
  );

  dssq_sif_writer u_sif (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .req_valid    (req_valid),
    .req          (req),
    .busy         (sif_busy),
    .done         (sif_done),
    .sif_clk      (sif_clk),
    .sif_enable_n (sif_enable_n),
    .sif_data     (sif_data)
  );

  // software registers; config is frozen only by software, not by the sequencer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q       <= '0;
      main_base_q <= 16'h0000;
      fuse_base_q <= 16'h0000;
      src_base_q  <= 16'h0000;
      aux_base_q  <= 16'h0000;
      pll_base_q  <= 16'h0000;
    end else if (reg_we) begin
      unique case (reg_addr)
        dssq_pkg::OFS_CTRL: begin
          cfg_q <= reg_wdata[dssq_pkg::CTRL_CFG_MSB:dssq_pkg::CTRL_CFG_LSB];
        end
        dssq_pkg::OFS_MAIN_BASE: main_base_q <= reg_wdata[15:0];
        dssq_pkg::OFS_FUSE_BASE: fuse_base_q <= reg_wdata[15:0];
        dssq_pkg::OFS_SRC_BASE:  src_base_q  <= reg_wdata[15:0];
        dssq_pkg::OFS_AUX_BASE:  aux_base_q  <= reg_wdata[15:0];
        dssq_pkg::OFS_PLL_BASE:  pll_base_q  <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_re) begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        dssq_pkg::OFS_CTRL:      reg_rdata[dssq_pkg::CTRL_CFG_MSB:dssq_pkg::CTRL_CFG_LSB] <= cfg_q;
        dssq_pkg::OFS_MAIN_BASE: reg_rdata[15:0] <= main_base_q;
        dssq_pkg::OFS_FUSE_BASE: reg_rdata[15:0] <= fuse_base_q;
        dssq_pkg::OFS_SRC_BASE:  reg_rdata[15:0] <= src_base_q;
        dssq_pkg::OFS_AUX_BASE:  reg_rdata[15:0] <= aux_base_q;
        dssq_pkg::OFS_PLL_BASE:  reg_rdata[15:0] <= pll_base_q;
        dssq_pkg::OFS_STATUS: begin
          reg_rdata[dssq_pkg::STAT_BUSY_BIT] <= (state_q != ST_IDLE);
          reg_rdata[dssq_pkg::STAT_TX_BIT]   <= transmit_enable_pin;
          reg_rdata[dssq_pkg::STAT_STATE_MSB:dssq_pkg::STAT_STATE_LSB] <= state_q;
          reg_rdata[dssq_pkg::STAT_CNT_MSB:dssq_pkg::STAT_CNT_LSB]     <= resync_cnt_q;
          reg_rdata[dssq_pkg::STAT_ALARM_MSB:dssq_pkg::STAT_ALARM_LSB] <= alarm_flag_q;
        end
        default: ;
      endcase
    end
  end

  // serial word for each write step
  always_comb begin
    req         = '0;
    is_write_st = 1'b1;
    skip_st     = 1'b0;
    unique case (state_q)
      ST_W_FUSE: begin
        req.addr = dssq_pkg::DEV_FUSE_CTRL;
        req.data = fuse_base_q;
        req.data[dssq_pkg::FUSE_SLEEP_BIT] = 1'b1;
      end
      ST_W_SRC: begin
        req.addr = dssq_pkg::DEV_SYNC_SRC;
        req.data = src_base_q;
      end
      ST_W_AUX: begin
        req.addr = dssq_pkg::DEV_SYNC_AUX;
        req.data = aux_base_q;
      end
      ST_W_MAIN: begin
        req.addr = dssq_pkg::DEV_MAIN_CTRL;
        req.data = main_base_q;
        req.data[dssq_pkg::CLKDIV_SYNC_BIT] = 1'b1;
      end
      ST_W_PLL: begin
        req.addr = dssq_pkg::DEV_PLL_CTRL;
        req.data = pll_base_q;
        req.data[dssq_pkg::PLL_NDIVSYNC_BIT] = 1'b1;
        skip_st = !cfg_q.pll_mode;
      end
      // divider sync off in single mode
      ST_DIS_CLK: begin
        req.addr = dssq_pkg::DEV_MAIN_CTRL;
        req.data = main_base_q;
        req.data[dssq_pkg::CLKDIV_SYNC_BIT] = 1'b0;
        skip_st = cfg_q.dual_mode;
      end
      ST_DIS_FIFO: begin
        req.addr = dssq_pkg::DEV_SYNC_SRC;
        req.data = src_base_q;
        req.data[dssq_pkg::FIFOIN_SEL_MSB:dssq_pkg::FIFOIN_SEL_LSB]   = dssq_pkg::SEL_NONE;
        req.data[dssq_pkg::FIFOOUT_SEL_MSB:dssq_pkg::FIFOOUT_SEL_LSB] = dssq_pkg::SEL_NONE;
        skip_st = !cfg_q.fifo_sync_off;
      end
      ST_DIS_PLL: begin
        req.addr = dssq_pkg::DEV_PLL_CTRL;
        req.data = pll_base_q;
        req.data[dssq_pkg::PLL_NDIVSYNC_BIT] = 1'b0;
        skip_st = !cfg_q.pll_mode;
      end
      default: is_write_st = 1'b0;
    endcase
  end

  // serial writes only after the reset phase
  assign req_valid = is_write_st && !skip_st && !sent_q && !sif_busy;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sent_q <= 1'b0;
    end else if (state_d != state_q) begin
      sent_q <= 1'b0;
    end else if (req_valid) begin
      sent_q <= 1'b1;
    end
  end

  // one pulse unless dual mode asks for a repeating sync
  // periodic allowed only in dual mode
  assign sync_done = (wait_q == 8'(dssq_pkg::PERIOD_CYC - 1))
                     && ((cfg_q.dual_mode && cfg_q.periodic)
                         ? (pulses_q == 4'(dssq_pkg::PERIODIC_COUNT)) : (pulses_q != 4'h0));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:     if (start_w) state_d = ST_RST;
      ST_RST:      if (wait_q == 8'(dssq_pkg::RST_CYC - 1)) state_d = ST_RECOVER;
      ST_RECOVER:  if (wait_q == 8'(dssq_pkg::RECOVER_CYC - 1)) state_d = ST_W_FUSE;
      ST_W_FUSE:   if (sif_done) state_d = ST_W_SRC;
      ST_W_SRC:    if (sif_done) state_d = ST_W_AUX;
      ST_W_AUX:    if (sif_done) state_d = ST_W_MAIN;
      ST_W_MAIN:   if (sif_done) state_d = ST_W_PLL;
      ST_W_PLL:    if (sif_done || skip_st) state_d = ST_SYNC;
      ST_SYNC:     if (sync_done) state_d = ST_DIS_CLK;
      ST_DIS_CLK:  if (sif_done || skip_st) state_d = ST_DIS_FIFO;
      ST_DIS_FIFO: if (sif_done || skip_st) state_d = ST_DIS_PLL;
      ST_DIS_PLL:  if (sif_done || skip_st) state_d = ST_TX;
      ST_TX:       state_d = ST_RUN;
      // resync from the sync configuration step
      ST_RUN:      if (alarm_hit || resync_w) state_d = ST_W_SRC;
    endcase
    if (stop_w) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // shared wait counter and pulse count
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_q   <= 8'h00;
      pulses_q <= 4'h0;
    end else if (state_d != state_q) begin
      wait_q   <= 8'h00;
      pulses_q <= 4'h0;
    end else if (state_q == ST_SYNC && wait_q == 8'(dssq_pkg::PERIOD_CYC - 1)) begin
      wait_q   <= 8'h00;
      pulses_q <= pulses_q + 4'h1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_low_device_reset <= 1'b1;
    end else begin
      active_low_device_reset <= (state_d != ST_RST);
    end
  end

  // lvds inputs up together before the first pulse; settle, then pulse
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvds_enable     <= 1'b0;
      lvds_sync_input <= 1'b0;
      input_strobe    <= 1'b0;
    end else begin
      if (state_d == ST_IDLE) begin
        lvds_enable <= 1'b0;
      end else if (state_d == ST_SYNC) begin
        lvds_enable <= 1'b1;
      end
      // a periodic run stops at its count, else the last window would add a fifth pulse
      if (state_q == ST_SYNC && wait_q == 8'(dssq_pkg::SETTLE_CYC - 1)
          && ((cfg_q.dual_mode && cfg_q.periodic)
              ? (pulses_q < 4'(dssq_pkg::PERIODIC_COUNT)) : (pulses_q == 4'h0))) begin
        lvds_sync_input <= cfg_q.pulse_sync;
        input_strobe    <= cfg_q.pulse_strobe;
      end else if (wait_q == 8'(dssq_pkg::SETTLE_CYC + dssq_pkg::PULSE_CYC - 1)
                   || state_q != ST_SYNC) begin
        lvds_sync_input <= 1'b0;
        input_strobe    <= 1'b0;
      end
    end
  end

  // transmit enable as the final step
  // low through reset, programming and sync
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      transmit_enable_pin <= 1'b0;
    end else begin
      transmit_enable_pin <= (state_d == ST_RUN);
    end
  end

  // sticky alarms; set wins over a software write-one clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_flag_q <= '0;
      resync_cnt_q <= 8'h00;
    end else begin
      if (reg_we && reg_addr == dssq_pkg::OFS_STATUS) begin
        alarm_flag_q <= (alarm_flag_q
                         & ~reg_wdata[dssq_pkg::STAT_ALARM_MSB:dssq_pkg::STAT_ALARM_LSB])
                        | alarm_s;
      end else begin
        alarm_flag_q <= alarm_flag_q | alarm_s;
      end
      if (state_q == ST_RUN && state_d == ST_W_SRC) begin
        resync_cnt_q <= resync_cnt_q + 8'h01;
      end
    end
  end

  AST_RST_WIDTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $fell(active_low_device_reset) |-> !active_low_device_reset[*2])
    else $error("device reset pulse too short");

  AST_NO_SIF_IN_RESET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !active_low_device_reset |-> sif_enable_n)
    else $error("serial write during device reset");

  AST_FUSE_SLEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (req_valid && state_q == ST_W_FUSE) |-> req.data[11])
    else $error("fuse sleep bit not set");

  AST_CLKDIV_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (req_valid && state_q == ST_W_MAIN) |-> req.data[2])
    else $error("divider sync not enabled");

  AST_PLL_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_q == ST_W_PLL && cfg_q.pll_mode) |-> ##[0:2] (req_valid && req.data[11]) || sent_q)
    else $error("pll divider sync not enabled");

  AST_PULSE_LVDS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(lvds_sync_input) |-> $past(lvds_enable, 7))
    else $error("sync pulse before lvds inputs up");

  AST_SINGLE_EDGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(lvds_sync_input) && !cfg_q.dual_mode) |-> pulses_q == 4'h0)
    else $error("repeated sync in single source mode");

  AST_CLKDIV_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_q == ST_SYNC && state_d == ST_DIS_CLK && !cfg_q.dual_mode)
    |-> ##[1:3] (req_valid && !req.data[2]))
    else $error("divider sync not cleared");

  AST_FIFO_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (req_valid && state_q == ST_DIS_FIFO) |-> req.data[15:8] == 8'h00)
    else $error("fifo selectors not cleared");

  AST_PLL_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (req_valid && state_q == ST_DIS_PLL) |-> !req.data[11])
    else $error("pll divider sync not cleared");

  AST_TX_ONLY_RUN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    transmit_enable_pin |-> (state_q == ST_RUN) && sif_enable_n && !lvds_sync_input)
    else $error("transmit enable outside run");

  AST_ALARM_DROP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_q == ST_RUN && alarm_hit && !stop_w) |=> !transmit_enable_pin && state_q == ST_W_SRC)
    else $error("alarm did not drop transmit enable");

endmodule

// ==== design/dssq_pkg.sv ====
package dssq_pkg;

  // host register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MAIN_BASE = 8'h04;
  localparam logic [7:0] OFS_FUSE_BASE = 8'h08;
  localparam logic [7:0] OFS_SRC_BASE  = 8'h0C;
  localparam logic [7:0] OFS_AUX_BASE  = 8'h10;
  localparam logic [7:0] OFS_PLL_BASE  = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // control register fields
  localparam int CTRL_START_BIT  = 0;
  localparam int CTRL_STOP_BIT   = 1;
  localparam int CTRL_RESYNC_BIT = 2;
  localparam int CTRL_CFG_LSB    = 4;
  localparam int CTRL_CFG_MSB    = 9;

  // status register fields
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_TX_BIT     = 1;
  localparam int STAT_STATE_LSB  = 4;
  localparam int STAT_STATE_MSB  = 7;
  localparam int STAT_CNT_LSB    = 8;
  localparam int STAT_CNT_MSB    = 15;
  localparam int STAT_ALARM_LSB  = 16;
  localparam int STAT_ALARM_MSB  = 18;

  // device serial register addresses
  localparam logic [6:0] DEV_MAIN_CTRL = 7'h00;
  localparam logic [6:0] DEV_PLL_CTRL  = 7'h18;
  localparam logic [6:0] DEV_FUSE_CTRL = 7'h1B;
  localparam logic [6:0] DEV_SYNC_AUX  = 7'h1F;
  localparam logic [6:0] DEV_SYNC_SRC  = 7'h20;

  // device register fields
  localparam int FUSE_SLEEP_BIT    = 11;
  localparam int CLKDIV_SYNC_BIT   = 2;
  localparam int PLL_NDIVSYNC_BIT  = 11;
  localparam int FIFOIN_SEL_MSB    = 15;
  localparam int FIFOIN_SEL_LSB    = 12;
  localparam int FIFOOUT_SEL_MSB   = 11;
  localparam int FIFOOUT_SEL_LSB   = 8;
  localparam logic [3:0] SEL_NONE  = 4'h0;

  // timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int T_RST_LOW_NS   = 25;
  localparam int RST_CYC        = (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_RECOVER_NS   = 100;
  localparam int RECOVER_CYC    = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC     = 8;
  localparam int PULSE_CYC      = 4;
  localparam int PERIOD_CYC     = 32;
  localparam int PERIODIC_COUNT = 4;
  localparam int SIF_HALF_CYC   = 2;
  localparam int SIF_WORD_BITS  = 24;
  localparam int ALARM_W        = 3;

  typedef struct packed {
    logic dual_mode;
    logic pll_mode;
    logic fifo_sync_off;
    logic periodic;
    logic pulse_strobe;
    logic pulse_sync;
  } dssq_cfg_t;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
  } dssq_sif_req_t;

endpackage

// ==== design/dssq_pin_sync.sv ====
`timescale 1ns/1ps
module dssq_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;

  // two flops per bit, first one read only by the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        meta_q[i]   <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        meta_q[i]   <= pin_in[i];
        pin_sync[i] <= meta_q[i];
      end
    end
  end

endmodule

// ==== design/dssq_sif_writer.sv ====
`timescale 1ns/1ps
module dssq_sif_writer (
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   req_valid,
  input  wire dssq_pkg::dssq_sif_req_t req,
  output logic                        busy,
  output logic                        done,
  output logic                        sif_clk,
  output logic                        sif_enable_n,
  output logic                        sif_data
);

  logic [7:0]  div_q;
  logic [4:0]  bit_q;
  logic [23:0] shift_q;

  assign sif_data = shift_q[23];

  // sclk from a divider: data moves on the fall, device samples on the rise
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy         <= 1'b0;
      done         <= 1'b0;
      sif_clk      <= 1'b0;
      sif_enable_n <= 1'b1;
      div_q        <= 8'h00;
      bit_q        <= 5'h00;
      shift_q      <= 24'h00_0000;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (req_valid) begin
          busy         <= 1'b1;
          sif_enable_n <= 1'b0;
          sif_clk      <= 1'b0;
          div_q        <= 8'h00;
          bit_q        <= 5'h00;
          shift_q      <= {1'b0, req.addr, req.data};
        end
      end else if (div_q == 8'(dssq_pkg::SIF_HALF_CYC - 1)) begin
        div_q <= 8'h00;
        if (!sif_clk) begin
          sif_clk <= 1'b1;
        end else begin
          sif_clk <= 1'b0;
          if (bit_q == 5'(dssq_pkg::SIF_WORD_BITS - 1)) begin
            busy         <= 1'b0;
            done         <= 1'b1;
            sif_enable_n <= 1'b1;
          end else begin
            bit_q   <= bit_q + 5'h01;
            shift_q <= {shift_q[22:0], 1'b0};
          end
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

endmodule

// ==== verification/dssq_dev_model.sv ====
`timescale 1ns/1ps
module dssq_dev_model (
  input wire logic active_low_device_reset,
  input wire logic transmit_enable_pin,
  input wire logic lvds_sync_input,
  input wire logic sif_clk,
  input wire logic sif_enable_n,
  input wire logic sif_data
);
  logic    [15:0] regs [0:127];
  logic    [23:0] shf   = 24'h00_0000;
  int             nbit  = 0;
  int             syncs = 0;
  int             bad   = 0;
  logic           rst_ok = 1'b0;
  realtime        t_low = -1.0;
  initial foreach (regs[j]) regs[j] = 16'h0000;
  always @(negedge active_low_device_reset) t_low = $realtime;
  always @(posedge active_low_device_reset) begin
    if (t_low >= 0.0) begin
      if ($realtime - t_low < 25.0) bad++;
      rst_ok = 1'b1;
    end
  end
  always @(posedge sif_clk) begin
    if (!sif_enable_n) begin
      shf = {shf[22:0], sif_data};
      nbit++;
    end
  end
  always @(posedge sif_enable_n) begin
    if (nbit == 24 && rst_ok) regs[shf[22:16]] = shf[15:0];
    else if (nbit != 0) bad++;
    nbit = 0;
  end
  always @(posedge lvds_sync_input) syncs++;
  always @(posedge transmit_enable_pin) if (syncs == 0) bad++;
endmodule

// ==== verification/test_dssq_host_seq.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; $display("wrong value at %0t: mismatch", $time); end end
module test_dssq_host_seq;
  logic                          ref_clk = 1'b0;
  logic                          sys_rst = 1'b1;
  logic                          reg_we = 1'b0;
  logic                          reg_re = 1'b0;
  logic [7:0]                    reg_addr = 8'h00;
  logic [31:0]                   reg_wdata = 32'h0000_0000;
  logic [31:0]                   reg_rdata;
  logic [31:0]                   rd_v;
  logic [dssq_pkg::ALARM_W-1:0]  alarm_pins = 3'h0;
  logic                          nrst, tx, lv_en, sync, strb, sclk, sen_n, sdat;
  logic [15:0]                   base [0:4];
  logic [5:0]                    cfg;
  logic [5:0]                    cfgs [0:3] = '{6'h03, 6'h3D, 6'h21, 6'h05};
  int                            err_total = 0;
  int                            comparisons = 0;
  int                            seed = 65;
  int                            s0, i, k;
  always #10 ref_clk = ~ref_clk;
  dssq_host_seq DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .alarm_pins(alarm_pins), .active_low_device_reset(nrst), .transmit_enable_pin(tx),
    .lvds_enable(lv_en), .lvds_sync_input(sync), .input_strobe(strb), .sif_clk(sclk),
    .sif_enable_n(sen_n), .sif_data(sdat));
  dssq_dev_model M (.active_low_device_reset(nrst), .transmit_enable_pin(tx),
    .lvds_sync_input(sync), .sif_clk(sclk), .sif_enable_n(sen_n), .sif_data(sdat));
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_re <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  // long waits bounded; a hang ends the run
  task automatic wait_tx(input logic v);
    for (k = 0; k < 4000 && tx !== v; k++) @(posedge ref_clk);
    if (tx !== v) begin err_total++; conclude(); end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(dssq_pkg::OFS_STATUS);
    `CHK(rd_v, 32'h0000_0000)
    rd(8'h1C);
    `CHK(rd_v, 32'h0000_0000)
    for (i = 0; i < 4; i++) begin
      cfg = cfgs[i];
      for (k = 0; k < 5; k++) begin
        base[k] = 16'($random(seed));
        wr(8'h04 + 8'(4 * k), {16'h0000, base[k]});
      end
      s0 = M.syncs;
      wr(dssq_pkg::OFS_CTRL, {22'h0, cfg, 4'h1});
      `CHK(tx, 1'b0)
      wait_tx(1'b1);
      `CHK(M.regs[7'h1B], base[1] | 16'h0800)
      `CHK(M.regs[7'h20], cfg[3] ? base[2] & 16'h00FF : base[2])
      `CHK(M.regs[7'h1F], base[3])
      `CHK(M.regs[7'h00], cfg[5] ? base[0] | 16'h0004 : base[0] & 16'hFFFB)
      if (cfg[4]) `CHK(M.regs[7'h18], base[4] & 16'hF7FF)
      `CHK(M.syncs - s0, (cfg[5] && cfg[2]) ? 4 : 1)
      rd(dssq_pkg::OFS_CTRL);
      `CHK(rd_v[9:4], cfg)
      if (i == 0) begin
        alarm_pins <= 3'h4;
        repeat (5) @(posedge ref_clk);
        `CHK(tx, 1'b0)
        alarm_pins <= 3'h0;
        wait_tx(1'b1);
        rd(dssq_pkg::OFS_STATUS);
        `CHK(rd_v[18:8], 11'h401)
        wr(dssq_pkg::OFS_STATUS, 32'h0007_0000);
        rd(dssq_pkg::OFS_STATUS);
        `CHK(rd_v[18:16], 3'h0)
      end
      wr(dssq_pkg::OFS_CTRL, {22'h0, cfg, 4'h2});
      rd(dssq_pkg::OFS_STATUS);
      `CHK(rd_v[7:0], 8'h00)
      $display("test %0d done", i);
    end
    `CHK(M.bad, 0)
    conclude();
  end
endmodule
